//--- src/lsr_consts.svh
// constants of the light sensor command and readout block
`ifndef LSR_CONSTS_SVH
`define LSR_CONSTS_SVH
// ==========================================================
// i2c addressing and byte counts
`define LSR_SLAVE_ADDR 7'h44
`define LSR_LAST_IDX_INT 2'h1
`define LSR_LAST_IDX_EXT 2'h3
`define LSR_BITS_PER_BYTE 4'h8
// ==========================================================
// command codes
`define LSR_CMD_POWER_DOWN 8'h8c
`define LSR_CMD_RESET 8'h0c
`define LSR_CMD_INT_VIS 8'h00
`define LSR_CMD_INT_COMP 8'h04
`define LSR_CMD_INT_DIFF 8'h08
`define LSR_CMD_EXT_VIS 8'h30
`define LSR_CMD_EXT_COMP 8'h34
`define LSR_CMD_EXT_DIFF 8'h38
`define LSR_CMD_TEST_BIT 7
// ==========================================================
// reset values
`define LSR_CMD_RESET_VAL 8'h0c
`define LSR_DATA_RESET_VAL 16'h0000
// ==========================================================
// timing counts
`define LSR_OSC_DIV 31
`define LSR_INT_OSC_CYCLES 32768
`endif

//--- src/lsr_pkg.sv
// types of the light sensor command and readout block
package lsr_pkg;
    // ==========================================================
    // i2c slave states, gray along address, ack, data
    typedef enum logic [2:0] {
        LSR_IDLE = 3'h0,
        LSR_ADDR = 3'h1,
        LSR_AACK = 3'h3,
        LSR_RX = 3'h2,
        LSR_RACK = 3'h6,
        LSR_TX = 3'h7,
        LSR_TACK = 3'h5
    } lsr_i2c_e;

    // ==========================================================
    // readout pair as sent over the bus
    typedef struct packed {
        logic [15:0] count;
        logic [15:0] result;
    } lsr_readout_s;
endpackage : lsr_pkg

//--- src/lsr_sensor_readout.sv
// i2c command slave and conversion control of the light sensor
`timescale 1ns/1ps
`default_nettype none
`include "lsr_consts.svh"

// How it works
// - one 8-bit command byte sets operation
// - four result bytes: conversion and cycle count
// - answers only slave address 1000100
// - every written byte replaces the command
// - no register index; two or four bytes
// - results update only at conversion end or 0CH reset
// - early read returns previous completed result
// - address-only write re-executes held command
// - read order: result lo, hi, count lo, hi
// - 00H/04H internal single diode, 100ms
// - 08H internal difference, 200ms total
// - difference integrates second diode first
// - 30H/34H/38H resent ends and restarts integration
// - msb set, except 8CH power-down: test, read back written value
// - internal modes release bus after two bytes
// - internal integration is 32768 oscillator cycles
// - 16-bit cycle counter latched at period end
// - power-down input high stops conversion
module lsr_sensor_readout
    import lsr_pkg::*;
#(
    parameter int unsigned OSC_DIV = `LSR_OSC_DIV,
    parameter int unsigned INT_OSC_CYCLES = `LSR_INT_OSC_CYCLES
)(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // i2c pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    // analog front end
    input wire logic power_down_input_i,
    input wire logic [15:0] visible_ir_photocurrent_i,
    input wire logic [15:0] compensation_photocurrent_i,
    // status
    output logic [7:0] command_o,
    output logic busy_o
);
    // ==========================================================
    // parameter check
    if (OSC_DIV < 2 || OSC_DIV > 256 || INT_OSC_CYCLES < 2 || INT_OSC_CYCLES > 65536)
    begin : g_bad_param
        $error("lsr_sensor_readout: parameter out of range");
    end

    // ==========================================================
    // pin synchronisers, a change counts once stages two and three agree
    logic [2:0] scl_sync_ff, sda_sync_ff, pd_sync_ff;
    logic scl_ff, sda_ff, pd_ff;
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            scl_sync_ff <= 3'h7;
            sda_sync_ff <= 3'h7;
            pd_sync_ff <= 3'h0;
            scl_ff <= 1'b1;
            sda_ff <= 1'b1;
            pd_ff <= 1'b0;
        end
        else
        begin
            scl_sync_ff <= {scl_sync_ff[1:0], scl_i};
            sda_sync_ff <= {sda_sync_ff[1:0], sda_i};
            pd_sync_ff <= {pd_sync_ff[1:0], power_down_input_i};
            if (scl_sync_ff[1] == scl_sync_ff[2]) scl_ff <= scl_sync_ff[2];
            if (sda_sync_ff[1] == sda_sync_ff[2]) sda_ff <= sda_sync_ff[2];
            if (pd_sync_ff[1] == pd_sync_ff[2]) pd_ff <= pd_sync_ff[2];
        end
    end
    wire logic scl_stb = scl_sync_ff[1] == scl_sync_ff[2];
    wire logic sda_stb = sda_sync_ff[1] == sda_sync_ff[2];
    wire logic scl_rise = scl_stb && scl_sync_ff[2] && !scl_ff;
    wire logic scl_fall = scl_stb && !scl_sync_ff[2] && scl_ff;
    wire logic start_w = sda_stb && !sda_sync_ff[2] && sda_ff && scl_ff;
    wire logic stop_w = sda_stb && sda_sync_ff[2] && !sda_ff && scl_ff;

    // ==========================================================
    // command decode
    function automatic logic is_ext(input logic [7:0] c);
        is_ext = c == `LSR_CMD_EXT_VIS || c == `LSR_CMD_EXT_COMP || c == `LSR_CMD_EXT_DIFF;
    endfunction : is_ext
    function automatic logic is_conv(input logic [7:0] c);
        is_conv = is_ext(c) || c == `LSR_CMD_INT_VIS || c == `LSR_CMD_INT_COMP
            || c == `LSR_CMD_INT_DIFF;
    endfunction : is_conv
    function automatic logic is_diff(input logic [7:0] c);
        is_diff = c == `LSR_CMD_INT_DIFF || c == `LSR_CMD_EXT_DIFF;
    endfunction : is_diff
    function automatic logic is_comp(input logic [7:0] c);
        is_comp = c == `LSR_CMD_INT_COMP || c == `LSR_CMD_EXT_COMP;
    endfunction : is_comp

    logic [7:0] cmd_ff, run_cmd_ff;
    logic exec_ff;
    lsr_readout_s data_ff, snap_ff;
    wire logic test_w = cmd_ff[`LSR_CMD_TEST_BIT] && cmd_ff != `LSR_CMD_POWER_DOWN;
    wire logic [1:0] last_idx = (is_conv(cmd_ff) && !is_ext(cmd_ff)) ?
        `LSR_LAST_IDX_INT : `LSR_LAST_IDX_EXT;

    // ==========================================================
    // i2c slave
    lsr_i2c_e st_ff;
    logic [3:0] bit_cnt_ff;
    logic [7:0] rx_sh_ff, tx_sh_ff;
    logic [1:0] idx_ff;
    logic rw_ff, wr_addr_ff, got_ff, more_ff;
    wire logic rx_done = st_ff == LSR_RX && scl_fall && bit_cnt_ff == `LSR_BITS_PER_BYTE;
    wire logic tx_load = scl_fall && ((st_ff == LSR_AACK && rw_ff)
        || (st_ff == LSR_TACK && more_ff && idx_ff != last_idx));
    wire logic [1:0] ld_idx = (st_ff == LSR_AACK) ? 2'h0 : idx_ff + 2'h1;
    // reads come from a snapshot taken at address ack so a burst never tears
    wire lsr_readout_s rd_src = (st_ff == LSR_AACK) ? data_ff : snap_ff;
    logic [7:0] ld_byte;
    always_comb
    begin
        case (ld_idx)
            2'h0: ld_byte = rd_src.result[7:0];
            2'h1: ld_byte = rd_src.result[15:8];
            2'h2: ld_byte = rd_src.count[7:0];
            default: ld_byte = rd_src.count[15:8];
        endcase
        if (test_w) ld_byte = cmd_ff;
    end

    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            st_ff <= LSR_IDLE;
            bit_cnt_ff <= 4'h0;
            rx_sh_ff <= 8'h00;
            tx_sh_ff <= 8'h00;
            idx_ff <= 2'h0;
            rw_ff <= 1'b0;
            wr_addr_ff <= 1'b0;
            got_ff <= 1'b0;
            more_ff <= 1'b0;
            sda_oe_n_o <= 1'b1;
            sda_o <= 1'b0;
            snap_ff <= '0;
        end
        else if (start_w)
        begin
            st_ff <= LSR_ADDR;
            bit_cnt_ff <= 4'h0;
            wr_addr_ff <= 1'b0;
            got_ff <= 1'b0;
            sda_oe_n_o <= 1'b1;
        end
        else if (stop_w)
        begin
            st_ff <= LSR_IDLE;
            sda_oe_n_o <= 1'b1;
        end
        else
        begin
            if (tx_load)
            begin
                st_ff <= LSR_TX;
                idx_ff <= ld_idx;
                tx_sh_ff <= ld_byte;
                sda_oe_n_o <= ld_byte[7];
                bit_cnt_ff <= 4'h0;
            end
            case (st_ff)
                LSR_ADDR, LSR_RX:
                begin
                    if (scl_rise)
                    begin
                        rx_sh_ff <= {rx_sh_ff[6:0], sda_ff};
                        bit_cnt_ff <= bit_cnt_ff + 4'h1;
                    end
                    if (scl_fall && bit_cnt_ff == `LSR_BITS_PER_BYTE)
                    begin
                        if (st_ff == LSR_RX)
                        begin
                            st_ff <= LSR_RACK;
                            got_ff <= 1'b1;
                            sda_oe_n_o <= 1'b0;
                        end
                        else if (rx_sh_ff[7:1] == `LSR_SLAVE_ADDR)
                        begin
                            st_ff <= LSR_AACK;
                            rw_ff <= rx_sh_ff[0];
                            sda_oe_n_o <= 1'b0;
                        end
                        else st_ff <= LSR_IDLE;
                    end
                end
                LSR_AACK:
                    if (scl_fall)
                    begin
                        snap_ff <= data_ff;
                        if (!rw_ff)
                        begin
                            st_ff <= LSR_RX;
                            wr_addr_ff <= 1'b1;
                            sda_oe_n_o <= 1'b1;
                            bit_cnt_ff <= 4'h0;
                        end
                    end
                LSR_RACK:
                    if (scl_fall)
                    begin
                        st_ff <= LSR_RX;
                        sda_oe_n_o <= 1'b1;
                        bit_cnt_ff <= 4'h0;
                    end
                LSR_TX:
                    if (scl_fall)
                    begin
                        if (bit_cnt_ff == 4'h7)
                        begin
                            st_ff <= LSR_TACK;
                            sda_oe_n_o <= 1'b1;
                        end
                        else
                        begin
                            tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
                            sda_oe_n_o <= tx_sh_ff[6];
                            bit_cnt_ff <= bit_cnt_ff + 4'h1;
                        end
                    end
                LSR_TACK:
                begin
                    if (scl_rise) more_ff <= !sda_ff;
                    // past the last byte the line stays released until the stop
                    if (scl_fall && !tx_load) st_ff <= LSR_IDLE;
                end
                default: ;
            endcase
        end
    end

    // ==========================================================
    // command byte and execute pulse
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cmd_ff <= `LSR_CMD_RESET_VAL;
            exec_ff <= 1'b0;
        end
        else
        begin
            exec_ff <= rx_done || (stop_w && wr_addr_ff && !got_ff);
            if (rx_done) cmd_ff <= rx_sh_ff;
        end
    end
    assign command_o = cmd_ff;

    // ==========================================================
    // oscillator tick from a divider of the core clock
    logic [7:0] div_ff;
    logic tick_ff;
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            div_ff <= 8'h00;
            tick_ff <= 1'b0;
        end
        else
        begin
            tick_ff <= div_ff == 8'(OSC_DIV - 1);
            div_ff <= (div_ff == 8'(OSC_DIV - 1)) ? 8'h00 : div_ff + 8'h01;
        end
    end

    // ==========================================================
    // integration control
    logic busy_ff, phase_ff;
    logic [15:0] icnt_ff, comp_ff;
    wire logic run_ext = is_ext(run_cmd_ff);
    wire logic run_diff = is_diff(run_cmd_ff);
    wire logic per_end = busy_ff && tick_ff && !run_ext
        && icnt_ff == 16'(INT_OSC_CYCLES - 1);
    wire logic done_w = !pd_ff && per_end && (!run_diff || phase_ff);
    wire logic ext_end = !pd_ff && exec_ff && busy_ff && run_ext;
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            busy_ff <= 1'b0;
            phase_ff <= 1'b0;
            icnt_ff <= 16'h0000;
            comp_ff <= 16'h0000;
            run_cmd_ff <= `LSR_CMD_RESET_VAL;
        end
        else if (pd_ff)
        begin
            busy_ff <= 1'b0;
            phase_ff <= 1'b0;
            icnt_ff <= 16'h0000;
        end
        else if (exec_ff)
        begin
            busy_ff <= is_conv(cmd_ff);
            run_cmd_ff <= cmd_ff;
            phase_ff <= 1'b0;
            icnt_ff <= 16'h0000;
        end
        else if (busy_ff && tick_ff)
        begin
            icnt_ff <= per_end ? 16'h0000 : icnt_ff + 16'h0001;
            if (per_end && run_diff)
            begin
                phase_ff <= !phase_ff;
                if (!phase_ff) comp_ff <= compensation_photocurrent_i;
            end
        end
    end
    assign busy_o = busy_ff;

    // ==========================================================
    // result latch, untouched until a period completes or a reset command clears it
    logic [15:0] conv_val;
    always_comb
    begin
        conv_val = is_comp(run_cmd_ff) ? compensation_photocurrent_i
            : visible_ir_photocurrent_i;
        if (run_diff)
            conv_val = visible_ir_photocurrent_i
                - (run_ext ? compensation_photocurrent_i : comp_ff);
    end
    always_ff @(posedge core_clk_i or posedge rst_i)
    begin
        if (rst_i) data_ff <= '0;
        else if (exec_ff && cmd_ff == `LSR_CMD_RESET) data_ff <= '0;
        else if (done_w || ext_end)
        begin
            data_ff.result <= conv_val;
            data_ff.count <= done_w ? icnt_ff + 16'h0001 : icnt_ff;
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    addr_ack_match_a: assert property (
        st_ff == LSR_AACK |-> rx_sh_ff[7:1] == `LSR_SLAVE_ADDR && !sda_oe_n_o)
        else $error("ack to a foreign address");
    first_byte_lo_a: assert property (
        tx_load && st_ff == LSR_AACK && !test_w |=> tx_sh_ff == $past(data_ff.result[7:0]))
        else $error("first byte wrong");
    test_echo_a: assert property (tx_load && test_w |=> tx_sh_ff == cmd_ff)
        else $error("test byte not echoed");
    int_two_bytes_a: assert property (
        st_ff == LSR_TX && is_conv(cmd_ff) && !is_ext(cmd_ff) |-> idx_ff <= 2'h1)
        else $error("counter byte sent in internal mode");
    result_hold_a: assert property (
        !$stable(data_ff) |-> $past(done_w || ext_end || exec_ff))
        else $error("result changed mid conversion");
    period_len_a: assert property (
        done_w && !run_diff |=> data_ff.count == 16'(INT_OSC_CYCLES))
        else $error("period length wrong");
    cmd_load_a: assert property (rx_done |=> cmd_ff == $past(rx_sh_ff) ##0 exec_ff)
        else $error("command byte not taken");
    reexec_a: assert property (
        stop_w && wr_addr_ff && !got_ff && !start_w |=> exec_ff)
        else $error("address-only write not re-executed");
    pd_stop_a: assert property (pd_ff |=> !busy_ff) else $error("converting in power down");
    idle_cmd_a: assert property (
        exec_ff && !pd_ff && !is_conv(cmd_ff) |=> !busy_ff[*2])
        else $error("conversion after power-down or reset command");
    // light is constant in the bench, so only this check sees the phase order
    diff_order_a: assert property (
        per_end && run_diff && !phase_ff && !pd_ff && !exec_ff
        |=> phase_ff && comp_ff == $past(compensation_photocurrent_i))
        else $error("difference phases out of order");
    read_burst_c: cover property (st_ff == LSR_TACK && idx_ff == 2'h1 && scl_fall);
    ext_period_c: cover property (ext_end);
    diff_done_c: cover property (done_w && run_diff);
    test_read_c: cover property (tx_load && test_w);
endmodule : lsr_sensor_readout
`default_nettype wire

//--- tb/lsr_i2c_master.sv
// i2c master model that faces the light sensor block
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// bit-level master; scl idles high and stands still between frames
module lsr_i2c_master (
    // clock
    input wire logic clk_i,
    // bus, sda is the wired level with pull-up
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_low_o,
    // one result per byte: {ack level, byte}, with 0 in place of the ack level on reads
    output logic res_stb_o,
    output logic [8:0] res_o
);
    initial
    begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
        res_stb_o = 1'b0;
        res_o = 9'h000;
    end

    task automatic tk(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : tk

    task automatic emit(input logic [8:0] v);
        res_o = v;
        res_stb_o = 1'b1;
        tk(1);
        res_stb_o = 1'b0;
    endtask : emit

    // one scl period of 8 core clocks (800 ns); sda moves mid-low, sampled mid-high
    task automatic bit_io(input logic b, output logic r);
        tk(2);
        sda_low_o = ~b;
        tk(2);
        scl_o = 1'b1;
        tk(2);
        r = sda_i;
        tk(2);
        scl_o = 1'b0;
    endtask : bit_io

    task automatic start();
        sda_low_o = 1'b1;
        tk(4);
        scl_o = 1'b0;
    endtask : start

    task automatic stop();
        tk(2);
        sda_low_o = 1'b1;
        tk(2);
        scl_o = 1'b1;
        tk(4);
        sda_low_o = 1'b0;
        tk(4);
    endtask : stop

    // byte out msb first, then sda released for the slave's ack
    task automatic put(input logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(b[i], r);
        bit_io(1'b1, r);
        emit({r, b});
    endtask : put

    // byte in; the last one is refused so the slave lets go before stop
    task automatic get(input logic last);
        logic [7:0] d;
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(1'b1, d[i]);
        bit_io(last, r);
        emit({1'b0, d});
    endtask : get
endmodule : lsr_i2c_master
`default_nettype wire

//--- tb/lsr_sensor_readout_test.sv
// self-checking bench of the light sensor command and readout block
`timescale 1ns/1ps
`default_nettype none
`include "lsr_consts.svh"
`define CHK(got, exp) \
    begin \
        check_count++; \
        if ((got) !== (exp)) \
        begin \
            fails++; \
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp); \
        end \
    end

module lsr_sensor_readout_test
    import lsr_pkg::*;
;
    // ==========================================================
    // short integration so the run stays small
    localparam int unsigned OSC_DIV = 2;
    localparam int unsigned INT_CYC = 64;
    logic core_clk;
    logic rst;
    logic power_down;
    logic [15:0] vis;
    logic [15:0] comp;
    logic scl;
    logic sda;
    logic m_low;
    logic sda_o;
    logic sda_oe_n;
    logic [7:0] command;
    logic busy;
    logic res_stb;
    logic [8:0] res;
    logic [31:0] seed = 32'hdb33;
    logic [17:0] exp_q[$];
    logic [17:0] e;
    logic [15:0] prev = 16'h0000;
    logic [7:0] int_cmd [3] = '{`LSR_CMD_INT_VIS, `LSR_CMD_INT_COMP, `LSR_CMD_INT_DIFF};
    logic [7:0] ext_cmd [3] = '{`LSR_CMD_EXT_VIS, `LSR_CMD_EXT_COMP, `LSR_CMD_EXT_DIFF};
    int fails = 0;
    int check_count = 0;
    int cyc = 0;
    int t0;

    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    always @(posedge core_clk) cyc <= cyc + 1;
    // wired sda: pulled up unless either side pulls low
    assign sda = ~m_low & (sda_oe_n | sda_o);

    lsr_sensor_readout #(.OSC_DIV(OSC_DIV), .INT_OSC_CYCLES(INT_CYC)) u_lsr_sensor_readout (
        .core_clk_i(core_clk), .rst_i(rst), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe_n_o(sda_oe_n), .power_down_input_i(power_down),
        .visible_ir_photocurrent_i(vis), .compensation_photocurrent_i(comp),
        .command_o(command), .busy_o(busy));
    lsr_i2c_master u_lsr_i2c_master (.clk_i(core_clk), .sda_i(sda), .scl_o(scl),
        .sda_low_o(m_low), .res_stb_o(res_stb), .res_o(res));

    // ==========================================================
    // result watcher: every byte on the bus is matched against the oldest note
    always @(posedge core_clk)
    begin
        if (res_stb)
        begin
            if (exp_q.size() == 0)
                `CHK(res, 9'h000)
            else
            begin
                e = exp_q.pop_front();
                `CHK(res & e[17:9], e[8:0])
            end
        end
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : wait_clk

    task automatic note(input logic [8:0] v, input logic [8:0] m);
        exp_q.push_back({m, v & m});
    endtask : note

    function automatic logic [15:0] conv(input int k);
        return (k == 0) ? vis : (k == 1) ? comp : vis - comp;
    endfunction : conv

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xorshift

    task automatic new_light();
        seed = xorshift(seed);
        vis = seed[15:0];
        comp = seed[31:16];
    endtask : new_light

    // write: address then n command bytes lsb first; a foreign address sees no ack at all
    task automatic wr(input logic [6:0] a, input int n, input logic [15:0] d);
        logic nak;
        nak = (a != `LSR_SLAVE_ADDR);
        note({nak, a, 1'b0}, 9'h1ff);
        u_lsr_i2c_master.start();
        u_lsr_i2c_master.put({a, 1'b0});
        for (int i = 0; i < n; i++)
        begin
            note({nak, d[8*i +: 8]}, 9'h1ff);
            u_lsr_i2c_master.put(d[8*i +: 8]);
        end
        u_lsr_i2c_master.stop();
    endtask : wr

    // read n bytes with no index byte; m masks bits that carry timing slack
    task automatic rd(input int n, input lsr_readout_s x, input logic [31:0] m);
        note({1'b0, `LSR_SLAVE_ADDR, 1'b1}, 9'h1ff);
        u_lsr_i2c_master.start();
        u_lsr_i2c_master.put({`LSR_SLAVE_ADDR, 1'b1});
        for (int i = 0; i < n; i++)
        begin
            note({1'b0, x[8*i +: 8]}, {1'b1, m[8*i +: 8]});
            u_lsr_i2c_master.get(i == n - 1);
        end
        u_lsr_i2c_master.stop();
    endtask : rd

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : test_done

    initial
    begin
        wait_clk(60000);
        `CHK(1'b0, 1'b1)
        test_done();
    end

    // ==========================================================
    // main sequence
    initial
    begin
        rst = 1'b1;
        power_down = 1'b0;
        vis = 16'h0000;
        comp = 16'h0000;
        wait_clk(4);
        rst = 1'b0;
        wait_clk(6);
        `CHK(command, `LSR_CMD_RESET_VAL)
        rd(4, 32'h0, 32'hffffffff);
        $display("reset test done");
        for (int k = 0; k < 3; k++)
        begin
            wr(`LSR_SLAVE_ADDR, 1, {8'h00, int_cmd[k]});
            `CHK(command, int_cmd[k])
            new_light();
            // conversion still running: old result, then the bus is released
            rd(3, {16'h00ff, prev}, 32'hffffffff);
            wait_clk(5 * INT_CYC * OSC_DIV);
            rd(3, {16'h00ff, conv(k)}, 32'hffffffff);
            // master stops right after the two result bytes
            rd(2, {16'h0000, conv(k)}, 32'hffffffff);
            prev = conv(k);
        end
        $display("internal timing test done");
        `CHK(busy, 1'b1)
        power_down = 1'b1;
        for (int n = 0; n < 20 && busy !== 1'b0; n++)
            wait_clk(1);
        `CHK(busy, 1'b0)
        power_down = 1'b0;
        $display("power-down pin test done");
        for (int k = 0; k < 3; k++)
        begin
            new_light();
            t0 = cyc;
            wr(`LSR_SLAVE_ADDR, 1, {8'h00, ext_cmd[k]});
            while (cyc < t0 + 266)
                wait_clk(1);
            // 266 clocks between commands is 133 ticks; low bits absorb divider phase
            wr(`LSR_SLAVE_ADDR, 1, {8'h00, ext_cmd[k]});
            rd(4, {16'd133, conv(k)}, 32'hfffc_ffff);
            new_light();
            wr(`LSR_SLAVE_ADDR, 0, 16'h0000);
            rd(4, {16'h0000, conv(k)}, 32'h0000_ffff);
        end
        $display("external timing test done");
        `CHK(busy, 1'b1)
        wr(`LSR_SLAVE_ADDR, 1, {8'h00, `LSR_CMD_POWER_DOWN});
        `CHK(busy, 1'b0)
        wr(7'h45, 1, 16'h0000);
        `CHK(command, `LSR_CMD_POWER_DOWN)
        wr(`LSR_SLAVE_ADDR, 1, 16'h00a5);
        `CHK(command, 8'ha5)
        rd(4, 32'ha5a5a5a5, 32'hffffffff);
        wr(`LSR_SLAVE_ADDR, 2, {`LSR_CMD_RESET, `LSR_CMD_EXT_VIS});
        `CHK(command, `LSR_CMD_RESET)
        rd(4, 32'h0, 32'hffffffff);
        $display("command test done");
        test_done();
    end
endmodule : lsr_sensor_readout_test
`default_nettype wire
